//--- logic/mrs_cfg.svh
// Constants of the microcontroller reset sequencer.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
`define MRS_CLK_MHZ 100
`define MRS_WAIT_PRE 256
`define MRS_WAIT_MAIN 256
`define MRS_WAIT_CYCLES (`MRS_WAIT_PRE * `MRS_WAIT_MAIN)
`define MRS_PC_RESET 11'h000
`define MRS_SP_RESET 3'h5
`define MRS_IRQ_TIMER_RESET 1'b1
`define MRS_PC_W 11
`define MRS_SP_W 3
`endif

//--- logic/mrs_pkg.sv
// Types of the microcontroller reset sequencer.
// Assumes mrs_cfg.svh on the include path.
`include "mrs_cfg.svh"
package mrs_pkg;
  typedef enum logic [1:0] {MRS_SRC_NONE, MRS_SRC_PIN, MRS_SRC_MONITOR, MRS_SRC_STACK} mrs_src_t;
  typedef enum logic [1:0] {MRS_ST_RESET, MRS_ST_WAIT, MRS_ST_RUN} mrs_state_t;
  typedef struct packed {
    logic [`MRS_PC_W-1:0] pc;
    logic [`MRS_SP_W-1:0] sp;
    logic load_pc;
    logic load_sp;
    logic load_irq_timer;
    logic irq_timer;
    logic keep_memory;
    logic buffer_undefined;
  } mrs_init_t;
endpackage

//--- logic/mrs_wait_timer.sv
// Oscillation stability wait counter: a prescaler and a main stage.
// Assumes a 100 MHz CLK and a clear from the sequencer while reset stands.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_cfg.svh"
module mrs_wait_timer #(
  parameter int PRE = `MRS_WAIT_PRE,
  parameter int MAIN = `MRS_WAIT_MAIN
) (
  input wire logic clk,
  input wire logic clear,
  input wire logic run,
  output logic done
);
  // Refuse stages that the counters cannot serve
  if (PRE < 1 || MAIN < 1)
  begin
    $error("Wait stages must be at least one count");
  end
  logic [$clog2(PRE+1)-1:0] pre_count;
  logic [$clog2(MAIN+1)-1:0] main_count;
  logic tick;
  // Prescaler gives a one-cycle enable every PRE clocks
  assign tick = run && !done && (pre_count == $bits(pre_count)'(PRE - 1));
  always_ff @(posedge clk)
  begin
    if (clear || tick)
      pre_count <= '0;
    else if (run && !done)
      pre_count <= pre_count + 1'b1;
  end
  // Main stage counts prescaler ticks up to MAIN
  always_ff @(posedge clk)
  begin
    if (clear)
      main_count <= '0;
    else if (tick)
      main_count <= main_count + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (clear)
      done <= 1'b0;
    else if (tick && main_count == $bits(main_count)'(MAIN - 1))
      done <= 1'b1;
  end
endmodule
`default_nettype wire

//--- logic/mrs_top.sv
// Reset sequencer of a small 4-bit microcontroller core.
// Combines pin, supply monitor and stack fault resets, then times the wait.
// Assumes the pin, monitor and stack inputs are synchronous to CLK.
// Assumes the core reloads its start values while CORE_RESET stands.
// Summary of operation
// - Three sources: pin, supply monitor, stack fault.
// - Execution restarts with program counter at zero.
// - Pin rising starts clock, then stability wait.
// - Wait lasts 256 times 256 system clocks.
// - Power-on reset follows the pin sequence.
// - Stack reset resumes at zero without wait.
// - Monitor reset stops the oscillator.
// - Monitor asserts at power-up and supply drop.
// - Pin/monitor: stack five, timer request set.
// - Standby reset keeps memory; transfer buffer undefined.
// Behaviour notes:
// A hard reset in any state drops RUN and stops the oscillator next edge.
// The stability wait restarts from zero when a hard reset cuts it short.
// A stack fault gives one cycle of CORE_RESET with the oscillator left running.
// A stack fault outside run is ignored, since the core is not executing.
// Memory retention is latched when a hard reset hits a core in standby.
// Supply drops are ignored unless software has enabled brownout reset.
// The monitor wins over the pin when both name the last source.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_cfg.svh"
module mrs_top #(
  parameter int WAIT_PRE = `MRS_WAIT_PRE,
  parameter int WAIT_MAIN = `MRS_WAIT_MAIN
) (
  // Clock and bench reset
  input wire logic CLK,
  input wire logic RST,
  // Reset sources and core status
  input wire logic RESET_N,
  input wire logic POWER_ON_DETECT,
  input wire logic SUPPLY_DROP_DETECT,
  input wire logic BROWNOUT_RESET_ENABLE,
  input wire logic STACK_FAULT,
  input wire logic STANDBY,
  // Sequencer controls
  output logic CORE_RESET,
  output logic OSC_ENABLE,
  output logic RUN,
  // Start values for the core
  output logic [`MRS_PC_W-1:0] INIT_PC,
  output logic [`MRS_SP_W-1:0] INIT_SP,
  output logic INIT_LOAD_PC,
  output logic INIT_LOAD_SP,
  output logic INIT_LOAD_IRQ_TIMER,
  output logic INIT_IRQ_TIMER,
  output logic KEEP_MEMORY,
  output logic TRANSFER_BUFFER_UNDEFINED,
  output var mrs_pkg::mrs_src_t LAST_SOURCE
);

  // Refuse wait stages that the counter cannot serve
  if (WAIT_PRE < 1 || WAIT_MAIN < 1)
  begin
    $error("Wait counts must be positive");
  end

  // Sequence state and the held start values
  mrs_pkg::mrs_state_t state;
  mrs_pkg::mrs_state_t next_state;
  mrs_pkg::mrs_init_t init;
  mrs_pkg::mrs_init_t next_init;
  // Decoded reset requests and timer handshake
  logic monitor_reset;
  logic hard_reset;
  logic stack_hit;
  logic keep_next;
  logic wait_done;
  logic timer_clear;

  // Supply monitor: power-up always, drops only when enabled
  assign monitor_reset = POWER_ON_DETECT || (SUPPLY_DROP_DETECT && BROWNOUT_RESET_ENABLE);
  // Pin low or monitor active holds everything
  assign hard_reset = !RESET_N || monitor_reset;

  // Stack fault only counts while the core is running
  assign stack_hit = STACK_FAULT && state == mrs_pkg::MRS_ST_RUN;

  // Retention is decided when the reset hits a running core, then held
  assign keep_next = state == mrs_pkg::MRS_ST_RUN ? STANDBY : init.keep_memory;

  // Build the initial state for the source in effect
  function automatic mrs_pkg::mrs_init_t make_init(input logic hard, input logic standby);
    mrs_pkg::mrs_init_t v;
    v = '0;
    v.pc = `MRS_PC_RESET;
    v.sp = `MRS_SP_RESET;
    v.load_pc = 1'b1;
    v.load_sp = 1'b1;
    // Only pin and monitor resets touch the timer request
    v.load_irq_timer = hard;
    v.irq_timer = hard ? `MRS_IRQ_TIMER_RESET : 1'b0;
    v.keep_memory = hard && standby;
    // Buffer contents never survive a reset
    v.buffer_undefined = 1'b1;
    return v;
  endfunction

  // Sequence: reset hold, stability wait, run
  // A hard reset in any state goes back to the hold
  always_comb
  begin
    next_state = state;
    unique case (state)
      mrs_pkg::MRS_ST_RESET:
        if (!hard_reset)
          next_state = mrs_pkg::MRS_ST_WAIT;
      mrs_pkg::MRS_ST_WAIT:
        if (hard_reset)
          next_state = mrs_pkg::MRS_ST_RESET;
        else if (wait_done)
          next_state = mrs_pkg::MRS_ST_RUN;
      mrs_pkg::MRS_ST_RUN:
        if (hard_reset)
          next_state = mrs_pkg::MRS_ST_RESET;
      default:
        next_state = mrs_pkg::MRS_ST_RESET;
    endcase
  end

  // State register
  always_ff @(posedge CLK)
  begin
    if (RST)
      state <= mrs_pkg::MRS_ST_RESET;
    else
      state <= next_state;
  end

  // Initial values chosen at the moment a reset is seen
  always_comb
  begin
    next_init = init;
    if (hard_reset)
      next_init = make_init(1'b1, keep_next);
    else if (stack_hit)
      next_init = make_init(1'b0, 1'b0);
  end

  // Start values register, left alone while idle in the hold
  always_ff @(posedge CLK)
  begin
    if (RST)
      init <= make_init(1'b1, 1'b0);
    else if (state != mrs_pkg::MRS_ST_RESET || hard_reset)
      init <= next_init;
  end

  // Last source seen, hard sources winning over the stack
  always_ff @(posedge CLK)
  begin
    if (RST)
      LAST_SOURCE <= mrs_pkg::MRS_SRC_NONE;
    else if (monitor_reset)
      LAST_SOURCE <= mrs_pkg::MRS_SRC_MONITOR;
    else if (!RESET_N)
      LAST_SOURCE <= mrs_pkg::MRS_SRC_PIN;
    else if (stack_hit)
      LAST_SOURCE <= mrs_pkg::MRS_SRC_STACK;
  end

  // Core reset pulse for a stack fault, held level for hard resets
  always_ff @(posedge CLK)
  begin
    if (RST)
      CORE_RESET <= 1'b1;
    else
      CORE_RESET <= hard_reset || next_state != mrs_pkg::MRS_ST_RUN || stack_hit;
  end

  // Oscillator off while held in reset
  always_ff @(posedge CLK)
  begin
    if (RST)
      OSC_ENABLE <= 1'b0;
    else
      OSC_ENABLE <= next_state != mrs_pkg::MRS_ST_RESET;
  end

  // Operating mode, dropped for one cycle on a stack fault
  always_ff @(posedge CLK)
  begin
    if (RST)
      RUN <= 1'b0;
    else
      RUN <= next_state == mrs_pkg::MRS_ST_RUN && !stack_hit;
  end

  // Timer restarts from zero outside the wait state
  assign timer_clear = RST || state != mrs_pkg::MRS_ST_WAIT || hard_reset;

  // Stability wait counter
  mrs_wait_timer #(
    .PRE(WAIT_PRE),
    .MAIN(WAIT_MAIN)
  ) u_wait (
    .clk(CLK),
    .clear(timer_clear),
    .run(state == mrs_pkg::MRS_ST_WAIT),
    .done(wait_done)
  );

  // Initial values out of the held register
  // They stand through the hold and the wait
  assign INIT_PC = init.pc;
  assign INIT_SP = init.sp;
  assign INIT_LOAD_PC = init.load_pc;
  assign INIT_LOAD_SP = init.load_sp;
  assign INIT_LOAD_IRQ_TIMER = init.load_irq_timer;
  assign INIT_IRQ_TIMER = init.irq_timer;
  assign KEEP_MEMORY = init.keep_memory;
  assign TRANSFER_BUFFER_UNDEFINED = init.buffer_undefined;
endmodule
`default_nettype wire

//--- tb/mrs_top_asserts.sv
// Port checker of the reset sequencer.
// Assumes it is bound into mrs_top with its wait counts.
`timescale 1ns/1ps
`default_nettype none
`include "mrs_cfg.svh"
module mrs_top_asserts #(
  parameter int WAIT_PRE = `MRS_WAIT_PRE,
  parameter int WAIT_MAIN = `MRS_WAIT_MAIN
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic RESET_N,
  input wire logic POWER_ON_DETECT,
  input wire logic SUPPLY_DROP_DETECT,
  input wire logic BROWNOUT_RESET_ENABLE,
  input wire logic STACK_FAULT,
  input wire logic CORE_RESET,
  input wire logic OSC_ENABLE,
  input wire logic RUN,
  input wire logic [`MRS_PC_W-1:0] INIT_PC,
  input wire logic [`MRS_SP_W-1:0] INIT_SP,
  input wire logic INIT_LOAD_IRQ_TIMER,
  input wire logic [1:0] LAST_SOURCE
);
  localparam int W = WAIT_PRE * WAIT_MAIN;
  int cnt;
  logic mon;
  logic hard;
  logic stk;
  // Monitor request, hard reset request and a stack fault taken in run
  assign mon = POWER_ON_DETECT | (SUPPLY_DROP_DETECT & BROWNOUT_RESET_ENABLE);
  assign hard = !RESET_N | mon;
  assign stk = RUN && STACK_FAULT && !hard;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Cycles spent waiting with the oscillator running
  always_ff @(posedge CLK)
  begin
    if (RST || RUN || !OSC_ENABLE) cnt <= 0;
    else cnt <= cnt + 1;
  end
  property p_hold; hard |=> CORE_RESET && !OSC_ENABLE && !RUN; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_osc; $rose(RESET_N) && !hard |=> OSC_ENABLE; endproperty
  a_osc: assert property (p_osc) else $error("osc");
  property p_wait; $rose(RUN) && LAST_SOURCE != mrs_pkg::MRS_SRC_STACK |-> cnt >= W; endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_bound; cnt <= W + 4; endproperty
  a_bound: assert property (p_bound) else $error("bound");
  property p_stk; stk |=> CORE_RESET && !INIT_LOAD_IRQ_TIMER && LAST_SOURCE == mrs_pkg::MRS_SRC_STACK; endproperty
  a_stk: assert property (p_stk) else $error("stack");
  property p_fast; stk ##1 (!STACK_FAULT && !hard) |=> RUN; endproperty
  a_fast: assert property (p_fast) else $error("fast");
  property p_init; CORE_RESET |-> INIT_PC == 11'h000 && INIT_SP == 3'h5; endproperty
  a_init: assert property (p_init) else $error("init");
  property p_src;
    hard |=> INIT_LOAD_IRQ_TIMER && (LAST_SOURCE == ($past(mon) ? mrs_pkg::MRS_SRC_MONITOR : mrs_pkg::MRS_SRC_PIN));
  endproperty
  a_src: assert property (p_src) else $error("source");
endmodule
bind mrs_top mrs_top_asserts #(
  .WAIT_PRE(WAIT_PRE),
  .WAIT_MAIN(WAIT_MAIN)
) u_mrs_top_asserts (
  .CLK(CLK),
  .RST(RST),
  .RESET_N(RESET_N),
  .POWER_ON_DETECT(POWER_ON_DETECT),
  .SUPPLY_DROP_DETECT(SUPPLY_DROP_DETECT),
  .BROWNOUT_RESET_ENABLE(BROWNOUT_RESET_ENABLE),
  .STACK_FAULT(STACK_FAULT),
  .CORE_RESET(CORE_RESET),
  .OSC_ENABLE(OSC_ENABLE),
  .RUN(RUN),
  .INIT_PC(INIT_PC),
  .INIT_SP(INIT_SP),
  .INIT_LOAD_IRQ_TIMER(INIT_LOAD_IRQ_TIMER),
  .LAST_SOURCE(LAST_SOURCE)
);
`default_nettype wire

//--- tb/mrs_supply_model.sv
// Model of the reset pin circuit and the supply monitor.
// Assumes the bench sets cmd at the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module mrs_supply_model (
  input wire logic clk,
  input wire logic [3:0] cmd,
  output logic reset_n,
  output logic power_on,
  output logic drop,
  output logic brownout_en
);
  // Pin, power-up, drop and software enable follow the command
  always_ff @(posedge clk)
  begin
    reset_n <= !cmd[0];
    power_on <= cmd[1];
    drop <= cmd[2];
    brownout_en <= !cmd[3];
  end
endmodule
`default_nettype wire

//--- tb/mcu_reset_sequencer_bench.sv
// Self-checking bench of the reset sequencer.
// Assumes a 100 MHz clock and a 4 by 4 stability wait.
`timescale 1ns/1ps
`default_nettype none
module mcu_reset_sequencer_bench;
  logic clk, rst, stby, fault, rn, por, drop, en, cr, osc, run, lpc, lsp, lirq, irq, keep, tbu;
  logic [3:0] cmd;
  logic [10:0] pc;
  logic [2:0] sp;
  mrs_pkg::mrs_src_t src;
  int errors, num_checks;
  mrs_supply_model u_mrs_supply_model (.clk(clk), .cmd(cmd), .reset_n(rn), .power_on(por), .drop(drop),
    .brownout_en(en));
  mrs_top #(.WAIT_PRE(4), .WAIT_MAIN(4)) u_mrs_top (.CLK(clk), .RST(rst), .RESET_N(rn),
    .POWER_ON_DETECT(por), .SUPPLY_DROP_DETECT(drop), .BROWNOUT_RESET_ENABLE(en), .STACK_FAULT(fault),
    .STANDBY(stby), .CORE_RESET(cr), .OSC_ENABLE(osc), .RUN(run), .INIT_PC(pc), .INIT_SP(sp),
    .INIT_LOAD_PC(lpc), .INIT_LOAD_SP(lsp), .INIT_LOAD_IRQ_TIMER(lirq), .INIT_IRQ_TIMER(irq),
    .KEEP_MEMORY(keep), .TRANSFER_BUFFER_UNDEFINED(tbu), .LAST_SOURCE(src));
  task chk(input logic [17:0] got, input logic [17:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wait_run;
    int n;
    n = 0;
    while (run !== 1'b1 && n < 99)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n >= 16 && n <= 24, 1);
  endtask
  // Hard reset from one source, then release and count the wait
  task hard(input logic [3:0] c, input logic [1:0] s, input logic sb);
    @(posedge clk);
    cmd <= c;
    stby <= sb;
    repeat (3) @(posedge clk);
    #1;
    chk({cr, osc, run, src}, {3'b100, s});
    chk({pc, sp, lirq, irq, tbu, keep}, {11'h000, 3'h5, 3'b111, sb});
    chk({lpc, lsp}, 2'b11);
    @(posedge clk);
    cmd <= 4'h0;
    stby <= 1'b0;
    wait_run;
  endtask
  // Drop with detection disabled, then a stack fault in run
  task others;
    @(posedge clk);
    cmd <= 4'hc;
    repeat (4) @(posedge clk);
    #1;
    chk(run, 1);
    @(posedge clk);
    cmd <= 4'h0;
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    #1;
    chk({cr, osc, run, lirq, src}, {4'b1100, mrs_pkg::MRS_SRC_STACK});
    @(posedge clk);
    #1;
    chk(run, 1);
  endtask
  // Clock of 10 ns period
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    errors++;
    finish_test;
  end
  // Main sequence
  initial
  begin
    {rst, stby, fault, cmd} = 7'h40;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wait_run;
    hard(4'h1, mrs_pkg::MRS_SRC_PIN, 1'b0);
    hard(4'h2, mrs_pkg::MRS_SRC_MONITOR, 1'b1);
    hard(4'h4, mrs_pkg::MRS_SRC_MONITOR, 1'b0);
    others;
    finish_test;
  end
endmodule
`default_nettype wire
